// >>> rcic_pkg.sv
// Constants, carriers and decode helpers for the routed interrupt controller.
// Assumes one clock domain; every user of it imports rcic_pkg::*.
package rcic_pkg;

   // Source and level counts
   localparam int NUM_LEVELS = 22;
   localparam int NUM_EXT_NUM = 11;
   localparam int NUM_EXT_LET = 4;
   localparam int NUM_EXT = 15;
   localparam int NUM_INT = 10;
   localparam int NUM_SRC = 25;

   // Controller selectors in a route entry
   localparam logic [1:0] CTRL_MASTER = 2'h0;
   localparam logic [1:0] CTRL_SLAVE1 = 2'h1;
   localparam logic [1:0] CTRL_SLAVE2 = 2'h2;

   // Master inputs carrying the two slaves; not routable targets
   localparam logic [2:0] CASCADE_S1_INPUT = 3'h2;
   localparam logic [2:0] CASCADE_S2_INPUT = 3'h5;

   // Vector bases of the three controllers
   localparam logic [7:0] VEC_BASE_MASTER = 8'h40;
   localparam logic [7:0] VEC_BASE_SLAVE1 = 8'h48;
   localparam logic [7:0] VEC_BASE_SLAVE2 = 8'h50;

   // Level index positions, 0 is the highest priority
   localparam logic [4:0] LVL_M0 = 5'h00;
   localparam logic [4:0] LVL_M1 = 5'h01;
   localparam logic [4:0] LVL_S1_BASE = 5'h02;
   localparam logic [4:0] LVL_M3 = 5'h0a;
   localparam logic [4:0] LVL_M4 = 5'h0b;
   localparam logic [4:0] LVL_S2_BASE = 5'h0c;
   localparam logic [4:0] LVL_M6 = 5'h14;
   localparam logic [4:0] LVL_M7 = 5'h15;

   // Values after reset
   localparam logic [21:0] PEND_RST = 22'h000000;
   localparam logic [24:0] PREV_RST = 25'h0000000;
   localparam logic [7:0] VECTOR_RST = 8'h00;

   // One router entry: enable, controller, controller input
   typedef struct packed {
      logic en;
      logic [1:0] ctrl;
      logic [2:0] inp;
   } rcic_route_s;

   // Request sources, active high, synchronous to the clock
   typedef struct packed {
      logic [9:0] internal_src;
      logic [3:0] lettered_external_request_inputs;
      logic [10:0] numbered_external_request_lines;
   } rcic_src_s;

   // Result of routing one source
   typedef struct packed {
      logic hit;
      logic [4:0] level;
   } rcic_slot_s;

   // Router entry to priority level index
   function automatic rcic_slot_s route_to_slot(input rcic_route_s r);
      rcic_slot_s s;
      s.hit = r.en;
      s.level = LVL_M0;
      case (r.ctrl)
         CTRL_MASTER: begin
            case (r.inp)
               3'h0: s.level = LVL_M0;
               3'h1: s.level = LVL_M1;
               3'h3: s.level = LVL_M3;
               3'h4: s.level = LVL_M4;
               3'h6: s.level = LVL_M6;
               3'h7: s.level = LVL_M7;
               default: s.hit = 1'b0;
            endcase
         end
         CTRL_SLAVE1: s.level = LVL_S1_BASE + {2'h0, r.inp};
         CTRL_SLAVE2: s.level = LVL_S2_BASE + {2'h0, r.inp};
         default: s.hit = 1'b0;
      endcase
      return s;
   endfunction

   // Priority level index to delivered vector
   function automatic logic [7:0] level_vector(input logic [4:0] lvl);
      logic [4:0] off;
      off = 5'h00;
      if (lvl < LVL_S1_BASE) begin
         off = lvl;
         return VEC_BASE_MASTER + {3'h0, off};
      end else if (lvl < LVL_M3) begin
         off = lvl - LVL_S1_BASE;
         return VEC_BASE_SLAVE1 + {3'h0, off};
      end else if (lvl == LVL_M3) begin
         return VEC_BASE_MASTER + 8'h03;
      end else if (lvl == LVL_M4) begin
         return VEC_BASE_MASTER + 8'h04;
      end else if (lvl < LVL_M6) begin
         off = lvl - LVL_S2_BASE;
         return VEC_BASE_SLAVE2 + {3'h0, off};
      end else if (lvl == LVL_M6) begin
         return VEC_BASE_MASTER + 8'h06;
      end else begin
         return VEC_BASE_MASTER + 8'h07;
      end
   endfunction

endpackage

// >>> rcic_prio_pick.sv
// Picks the highest pending level and its vector, purely combinational.
// Assumes the caller registers whatever it takes from these outputs.
`timescale 1ns/1ps
module rcic_prio_pick
   import rcic_pkg::*;
(
   input wire logic [21:0] pend, // Pending levels, bit 0 highest
   output logic any, // Some level pending
   output logic [4:0] top_level, // Highest pending level index
   output logic [7:0] top_vector // Vector of that level
);

   // Scan from lowest to highest so the highest pending wins
   always_comb begin
      any = |pend;
      top_level = LVL_M0;
      for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
         if (pend[i]) begin
            top_level = 5'(i); // see [R1] see [R9]
         end
      end
      top_vector = level_vector(top_level); // see [R6] see [R7] see [R8]
   end

endmodule

// >>> rcic_ctrl.sv
// Routed, cascaded interrupt controller: router, request latching,
// 22-level ranking, vector delivery and a separate non-maskable path.
// Assumes all inputs synchronous to mclk and the router table held
// steady by its owner; route changes apply on the next cycle.
//
// Notes on behaviour
// [R1] Routed requests are ranked into 22 levels; highest pending goes out.
// [R2] Fifteen external inputs: eleven numbered lines and four lettered ones.
// [R3] Router maps each source to a controller input, fixing its level.
// [R4] After initialisation all external inputs are rising-edge triggered.
// [R5] A separate non-maskable request path exists beside the 22 levels.
// [R6] Master inputs zero to seven give vectors 0x40 to 0x47.
// [R7] First slave inputs zero to seven give vectors 0x48 to 0x4f.
// [R8] Second slave inputs zero to seven give vectors 0x50 to 0x57.
// [R9] Order: master 0-1, slave1, master 3-4, slave2, master 6-7.
// [R10] Acknowledge returns the vector of the serviced input.
// [R11] An edge stays pending until acknowledged, even if input drops.
// [R12] A source with no route never raises a request.
`timescale 1ns/1ps
module rcic_ctrl
   import rcic_pkg::*;
(
   input wire logic mclk, // System clock, 100 MHz
   input wire logic srst, // Synchronous reset, active high
   input wire logic ce, // Clock enable, freezes all state when low
   input wire logic init_done, // High once initialisation is complete
   input wire rcic_src_s src, // All request sources, active high
   input wire rcic_route_s [24:0] route_map, // Router table per source
   input wire logic nmi_in, // Non-maskable request, rising edge
   input wire logic int_ack, // Processor takes the ranked request
   input wire logic nmi_ack, // Processor takes the non-maskable one
   output logic irq_req, // Ranked request to the processor
   output logic nmi_req, // Non-maskable request to the processor
   output logic [7:0] vector_q, // Vector of the serviced input
   output logic vector_valid_q, // One-cycle mark of a new vector
   output logic [21:0] pending_q // Pending levels, bit 0 highest
);

   // Handshake states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_REQ = 2'b10
   } rcic_state_e;

   rcic_state_e state_q;
   rcic_state_e state_d;
   logic [24:0] src_vec;
   logic [24:0] prev_q;
   logic [24:0] prev_d;
   logic [24:0] trig;
   logic [21:0] src_set [NUM_SRC];
   logic [21:0] set_lvl;
   logic [21:0] clr_lvl;
   logic [21:0] pending_d;
   logic [7:0] vector_d;
   logic vector_valid_d;
   logic nmi_prev_q;
   logic nmi_prev_d;
   logic nmi_pend_q;
   logic nmi_pend_d;
   logic any;
   logic [4:0] top_level;
   logic [7:0] top_vector;
   logic take;
   logic [24:0] src_hit;
   logic [4:0] src_level [NUM_SRC];
   logic [24:0] src_rise;

   // Level index to a one-hot mask, shared by the set and clear paths
   function automatic logic [21:0] level_mask(input logic [4:0] lvl);
      logic [21:0] m;
      m = 22'h000000;
      for (int k = 0; k < NUM_LEVELS; k++) begin
         if (lvl == 5'(k)) begin
            m[k] = 1'b1;
         end
      end
      return m;
   endfunction

   // Rising edge of an input against its previous enabled sample
   function automatic logic rise(input logic cur, input logic prev);
      return cur & ~prev;
   endfunction

   // Flatten the source groups into one vector, external lines first
   assign src_vec = {src.internal_src,
                     src.lettered_external_request_inputs,
                     src.numbered_external_request_lines}; // see [R2]

   // Per-source trigger and routing to a one-hot level request
   for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
      rcic_slot_s slot;
      // Router decode; cascade inputs and bad selectors give no hit
      assign slot = route_to_slot(route_map[i]); // see [R3]
      assign src_hit[i] = slot.hit;
      assign src_level[i] = slot.level;
      // Edge against the sample taken at the last enabled edge
      assign src_rise[i] = rise(src_vec[i], prev_q[i]);
      // Level sensing only until init completes; edge after
      assign trig[i] = init_done ? src_rise[i] : src_vec[i]; // see [R4]
      // Unrouted or cascade-input targets contribute nothing
      assign src_set[i] = (src_hit[i] && trig[i])
                          ? level_mask(src_level[i])
                          : 22'h000000; // see [R12]
   end

   // Merge all routed requests per level
   always_comb begin
      set_lvl = 22'h000000;
      for (int i = 0; i < NUM_SRC; i++) begin
         set_lvl = set_lvl | src_set[i]; // see [R1]
      end
   end

   // Ranking of what is pending
   rcic_prio_pick u_pick (
      .pend(pending_q),
      .any(any),
      .top_level(top_level),
      .top_vector(top_vector)
   );

   // Request is raised only from the registered state
   assign irq_req = (state_q == ST_REQ);
   assign take = irq_req && int_ack;
   assign nmi_req = nmi_pend_q; // see [R5]

   // Handshake next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (any) begin
               state_d = ST_REQ;
            end
         end
         ST_REQ: begin
            if (take) begin
               // One idle cycle lets the next winner settle
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // Edge history follows the sources on every enabled cycle
   always_comb begin
      prev_d = src_vec;
   end

   // Clear mask of the level served in this cycle
   always_comb begin
      clr_lvl = 22'h000000;
      if (take) begin
         clr_lvl = level_mask(top_level);
      end
   end

   // A new edge in the acknowledge cycle wins over the clear
   always_comb begin
      pending_d = (pending_q & ~clr_lvl) | set_lvl; // see [R11]
   end

   // Vector of the served level, held until the next acknowledge
   always_comb begin
      vector_d = vector_q;
      vector_valid_d = 1'b0;
      if (take) begin
         vector_d = top_vector; // see [R10]
         vector_valid_d = 1'b1;
      end
   end

   // Non-maskable path, edge latched, set beats clear
   always_comb begin
      nmi_prev_d = nmi_in;
      nmi_pend_d = nmi_pend_q & ~nmi_ack;
      if (rise(nmi_in, nmi_prev_q)) begin
         nmi_pend_d = 1'b1; // see [R5]
      end
   end

   // Handshake state; reset acts whatever the enable is
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_q <= ST_IDLE;
      end else if (ce) begin
         state_q <= state_d;
      end
   end

   // Pending levels; enable low freezes them
   always_ff @(posedge mclk) begin
      if (srst) begin
         pending_q <= PEND_RST;
      end else if (ce) begin
         pending_q <= pending_d;
      end
   end

   // Edge history; a source high at release counts as an edge
   always_ff @(posedge mclk) begin
      if (srst) begin
         prev_q <= PREV_RST;
      end else if (ce) begin
         prev_q <= prev_d;
      end
   end

   // Delivered vector and its one-cycle mark
   always_ff @(posedge mclk) begin
      if (srst) begin
         vector_q <= VECTOR_RST;
         vector_valid_q <= 1'b0;
      end else if (ce) begin
         vector_q <= vector_d;
         vector_valid_q <= vector_valid_d;
      end
   end

   // Non-maskable history and pending flag
   always_ff @(posedge mclk) begin
      if (srst) begin
         nmi_prev_q <= 1'b0;
         nmi_pend_q <= 1'b0;
      end else if (ce) begin
         nmi_prev_q <= nmi_prev_d;
         nmi_pend_q <= nmi_pend_d;
      end
   end

endmodule

// >>> rcic_ctrl_monitor.sv
// Checker on the controller ports, bound to every rcic_ctrl.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module rcic_monitor (
   input wire logic mclk, // Clock
   input wire logic srst, // Reset
   input wire logic ce, // Enable
   input wire logic nmi_in, // NMI in
   input wire logic int_ack, // Ack
   input wire logic nmi_ack, // NMI ack
   input wire logic irq_req, // Request
   input wire logic nmi_req, // NMI out
   input wire logic [7:0] vector_q, // Vector
   input wire logic vector_valid_q, // Mark
   input wire logic [21:0] pending_q // Pending
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   // Accepted acknowledge, then a one-cycle mark
   sequence s_ack;
      irq_req && int_ack && ce;
   endsequence
   sequence s_mark;
      vector_valid_q ##1 !vector_valid_q;
   endsequence
   a_ack_mark: assert property (s_ack |=> s_mark)
      else $error("no vector mark");
   a_mark_cause: assert property (
      vector_valid_q |-> !irq_req && $past(irq_req) && $past(int_ack) &&
      $past(ce))
      else $error("mark without ack");
   // Cascade inputs 2 and 5 of the master never deliver
   a_vec_range: assert property (
      vector_valid_q |-> vector_q inside {[8'h40:8'h57]} &&
      !(vector_q inside {8'h42, 8'h45}))
      else $error("vector out of range");
   a_irq_cause: assert property (irq_req |-> |pending_q)
      else $error("request with nothing pending");
   a_irq_back: assert property (
      vector_valid_q && ce && |pending_q |=> irq_req)
      else $error("request not raised again");
   a_pend_hold: assert property (
      ce && !(irq_req && int_ack) |=> &(pending_q | ~$past(pending_q)))
      else $error("pending lost without ack");
   a_nmi_set: assert property (ce && $rose(nmi_in) |=> nmi_req)
      else $error("nmi not raised");
   a_nmi_hold: assert property (
      nmi_req && !(nmi_ack && ce) |=> nmi_req)
      else $error("nmi dropped early");
   a_nmi_clear: assert property (
      nmi_req && nmi_ack && ce && !nmi_in |=> !nmi_req)
      else $error("nmi not cleared");
endmodule

bind rcic_ctrl rcic_monitor u_mon (.mclk(mclk), .srst(srst), .ce(ce),
   .nmi_in(nmi_in), .int_ack(int_ack), .nmi_ack(nmi_ack),
   .irq_req(irq_req), .nmi_req(nmi_req), .vector_q(vector_q),
   .vector_valid_q(vector_valid_q), .pending_q(pending_q));

// >>> rcic_cpu_model.sv
// Processor side: acknowledges ranked requests after a set lag.
// Assumes requests stand as levels until acknowledged.
`timescale 1ns/1ps
module rcic_cpu_model (
   input wire logic mclk, // Clock
   input wire logic srst, // Reset
   input wire logic run, // Allow acknowledges
   input wire logic [3:0] lag, // Cycles to wait first
   input wire logic irq_req, // Ranked request
   output logic int_ack // One-cycle acknowledge
);
   logic [3:0] cnt_q;
   // Pulse drops after one edge, so acks stay two cycles apart
   always_ff @(posedge mclk) begin
      if (srst || !irq_req || int_ack) begin
         cnt_q <= 4'h0;
         int_ack <= 1'b0;
      end else if (run && cnt_q >= lag) begin
         int_ack <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule

// >>> routed_cascaded_interrupt_controller_test.sv
// Self-checking bench for the routed interrupt controller.
// Assumes rcic_pkg, rcic_ctrl, its monitor and the cpu model.
`timescale 1ns/1ps
module routed_cascaded_interrupt_controller_test
   import rcic_pkg::*;
;
   // Vectors in falling priority order
   localparam logic [7:0] EV [22] = '{8'h40, 8'h41, 8'h48, 8'h49, 8'h4a,
      8'h4b, 8'h4c, 8'h4d, 8'h4e, 8'h4f, 8'h43, 8'h44, 8'h50, 8'h51,
      8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h46, 8'h47};
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic init_done = 1'b1;
   logic nmi_in = 1'b0;
   logic nmi_ack = 1'b0;
   logic run = 1'b0;
   logic [3:0] lag = 4'h0;
   rcic_src_s src = '0;
   rcic_route_s [24:0] route_map = '0;
   logic int_ack, irq_req, nmi_req, vector_valid_q;
   logic [7:0] vector_q;
   logic [21:0] pending_q;
   int n_mismatch = 0;
   int comparisons = 0;
   int cyc = 0;

   rcic_ctrl DUT (.mclk(mclk), .srst(srst), .ce(ce), .init_done(init_done),
      .src(src), .route_map(route_map), .nmi_in(nmi_in),
      .int_ack(int_ack), .nmi_ack(nmi_ack), .irq_req(irq_req),
      .nmi_req(nmi_req), .vector_q(vector_q),
      .vector_valid_q(vector_valid_q), .pending_q(pending_q));
   rcic_cpu_model cpu (.mclk(mclk), .srst(srst), .run(run), .lag(lag),
      .irq_req(irq_req), .int_ack(int_ack));

   // Route entry that should deliver vector v
   function automatic rcic_route_s rt(logic [7:0] v);
      return '{en: 1'b1, inp: v[2:0],
         ctrl: v[4] ? CTRL_SLAVE2 : (v[3] ? CTRL_SLAVE1 : CTRL_MASTER)};
   endfunction

   task automatic chk(input logic ok, input string m);
      comparisons++;
      if (!ok) begin
         n_mismatch++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask

   // Bounded wait for the next vector mark
   task automatic wv(input logic [7:0] e);
      int k;
      k = 0;
      do begin
         @(posedge mclk);
         #1;
         k++;
      end while (vector_valid_q !== 1'b1 && k < 40);
      chk(vector_valid_q === 1'b1 && vector_q === e, "wrong vector");
   endtask

   task test_done();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task t_unrouted();
      @(posedge mclk);
      route_map[21] <= '{1'b1, CTRL_MASTER, 3'h5};
      route_map[22] <= '{1'b1, CTRL_MASTER, 3'h2};
      route_map[23] <= '{1'b1, 2'h3, 3'h0};
      route_map[24] <= '{1'b0, CTRL_SLAVE1, 3'h0};
      src <= rcic_src_s'(25'h1e00000);
      repeat (4) @(posedge mclk);
      src <= '0;
      #1;
      chk(pending_q === '0 && irq_req === 1'b0, "unrouted");
      $display("unrouted done");
   endtask

   // All 22 levels at once, served strictly by rank
   task t_order();
      @(posedge mclk);
      for (int l = 0; l < 22; l++) begin
         route_map[l] <= rt(EV[l]);
      end
      @(posedge mclk);
      src <= rcic_src_s'(25'h03fffff);
      @(posedge mclk);
      src <= '0;
      repeat (3) @(posedge mclk);
      #1;
      chk(pending_q === 22'h3fffff, "pending lost");
      @(posedge mclk);
      run <= 1'b1;
      for (int l = 0; l < 22; l++) begin
         wv(EV[l]);
      end
      $display("order done");
   endtask

   // Level sensing before init, edge sensing after
   task t_level();
      @(posedge mclk);
      init_done <= 1'b0;
      lag <= 4'h3;
      route_map[0] <= rt(8'h47);
      src <= rcic_src_s'(25'h0000001);
      wv(8'h47);
      wv(8'h47);
      @(posedge mclk);
      init_done <= 1'b1;
      repeat (12) @(posedge mclk);
      #1;
      chk(irq_req === 1'b0 && pending_q === '0, "held re-pend");
      @(posedge mclk);
      src <= '0;
      $display("level done");
   endtask

   // Enable low freezes all state; the held edge counts once it is high
   task t_freeze();
      @(posedge mclk);
      ce <= 1'b0;
      src <= rcic_src_s'(25'h0000001);
      repeat (3) @(posedge mclk);
      #1;
      chk(pending_q === '0 && irq_req === 1'b0, "not frozen");
      @(posedge mclk);
      ce <= 1'b1;
      wv(8'h47);
      @(posedge mclk);
      src <= '0;
      $display("freeze done");
   endtask

   task t_nmi();
      @(posedge mclk);
      nmi_in <= 1'b1;
      @(posedge mclk);
      nmi_in <= 1'b0;
      repeat (3) @(posedge mclk);
      nmi_ack <= 1'b1;
      #1;
      chk(nmi_req === 1'b1 && irq_req === 1'b0, "nmi missing");
      @(posedge mclk);
      nmi_ack <= 1'b0;
      #1;
      chk(nmi_req === 1'b0, "nmi stuck");
      $display("nmi done");
   endtask

   initial begin
      forever #5 mclk = ~mclk;
   end

   // Ceiling well above the roughly 130 cycles the tests need
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         test_done();
      end
   end

   initial begin
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      #1;
      chk({irq_req, nmi_req, vector_valid_q, vector_q, pending_q} === '0,
         "reset state");
      t_unrouted();
      t_order();
      t_level();
      t_freeze();
      t_nmi();
      test_done();
   end
endmodule
